// file: rtl/fst_pkg.sv
/*
 * Constants and types for the flash strobe and timeout control registers.
 * Assumes a 10 MHz system clock and an external serial slave engine that
 * presents byte-wide register accesses.
 */
package fst_pkg;

    // ****************************************************************
    // Register offsets and reset values.
    // ****************************************************************
    localparam logic [7:0] FST_TORCH_OFS    = 8'hA0;
    localparam logic [7:0] FST_FLASH_OFS    = 8'hB0;
    localparam logic [7:0] FST_DUR_OFS      = 8'hC0;
    localparam logic [7:0] FST_FLASH_RST    = 8'h68;
    localparam logic [7:0] FST_DUR_RST      = 8'h4F;
    localparam logic [7:0] FST_RDATA_RST    = 8'h00;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int FST_SENSE_BIT  = 7;
    localparam int FST_LEVEL_LSB  = 3;
    localparam int FST_MODE_LSB   = 0;
    localparam int FST_LIMIT_LSB  = 5;
    localparam int FST_CODE_LSB   = 0;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int FST_CLK_KHZ         = 10000;
    localparam int FST_TIMEOUT_STEP_MS = 32;
    localparam int FST_STEP_CYCLES     = FST_TIMEOUT_STEP_MS * FST_CLK_KHZ;
    localparam int FST_CODE_STEPS      = 32;

    // ****************************************************************
    // Types.
    // ****************************************************************
    typedef enum logic [2:0] {
        FST_MODE_OFF       = 3'h0,
        FST_MODE_IND       = 3'h1,
        FST_MODE_TORCH     = 3'h2,
        FST_MODE_FLASH     = 3'h3,
        FST_MODE_VOUT      = 3'h4,
        FST_MODE_VOUT_IND  = 3'h5,
        FST_MODE_VOUT_TRCH = 3'h6,
        FST_MODE_VOUT_FLSH = 3'h7
    } fst_mode_t;

    typedef struct packed {
        logic       trigger_sense_select;
        logic [3:0] flash_level_code;
        fst_mode_t  mode;
    } fst_level_reg_t;

    typedef struct packed {
        logic [1:0] switch_limit_sel;
        logic [4:0] timeout_code;
    } fst_dur_reg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } fst_req_t;

endpackage : fst_pkg

// file: rtl/fst_flash_strobe_timeout_ctrl.sv
/*
 * Flash level/strobe and flash duration registers with the strobe-driven
 * flash pulse timer.
 * Assumes the serial slave engine delivers one-cycle write and read strobes
 * and a torch register outside that shares the mode field through the mirror
 * port. The trigger pin is synchronous to clk_i.
 * Assumes STEP_CYCLES clock cycles make one 32 ms timeout step, so that the
 * default suits a 10 MHz clock and a small value suits simulation.
 * Assumes the torch register copies mode_o whenever it changes, so that the
 * two mode copies stay equal, also after a timeout clears the flash selection.
 * Assumes the converter and current sources act on flash_on_o, the current
 * code and the limit select one cycle after they change.
 */
// Summary of operation
// - Level bit 7 picks trigger sense: 0 level (reset), 1 edge.
// - Level sense: trigger rise lights flash until pin low or timeout.
// - Edge sense: trigger rise lights flash for the whole timeout.
// - Duration bits 4..0 hold the timeout code limiting pulse length.
// - Timeout is 32 ms times code plus one, 32 to 1024 ms.
// - Duration bits 6..5 hold the peak switch current-limit select.
// - Duration bit 7 is unused and reads back zero.
// - Level bits 6..3 hold the four-bit flash current code.
// - Writing level mode bits also updates the torch mirror copy.
// - Mode field selects off, indicator, torch, flash, plus voltage output.
`timescale 1ns/1ns
`default_nettype none
module fst_flash_strobe_timeout_ctrl
    import fst_pkg::*;
#(
    parameter int STEP_CYCLES = FST_STEP_CYCLES
) (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Register access from the serial slave engine.
    input  wire fst_req_t   req_i,
    output var  logic [7:0] reg_rdata_o,
    // Mode mirror shared with the torch register.
    input  wire logic       torch_mode_we_i,
    input  wire logic [2:0] torch_mode_i,
    output var  logic [2:0] mode_o,
    // Flash trigger pin.
    input  wire logic       trigger_i,
    // Converter and current source controls.
    output var  logic       flash_on_o,
    output var  logic [3:0] flash_level_code_o,
    output var  logic [1:0] switch_limit_sel_o,
    output var  logic       timeout_pulse_o
);

    localparam int CNT_W    = $clog2(STEP_CYCLES * FST_CODE_STEPS + 1);
    localparam int STEP_MAX = 2 ** 25;

    // ****************************************************************
    // Parameter checks.
    // ****************************************************************
    // The pulse limit is formed in 32 bits, so the step is bounded.
    if (STEP_CYCLES < 1) begin : g_step_low
        $error("STEP_CYCLES must be at least one.");
    end
    if (STEP_CYCLES > STEP_MAX) begin : g_step_high
        $error("STEP_CYCLES is too large for the pulse counter.");
    end
    // Five timeout code bits give exactly 32 steps.
    if (FST_CODE_STEPS != 32) begin : g_code_steps
        $error("FST_CODE_STEPS must match the five-bit timeout code.");
    end

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        fst_level_reg_t   lvl;
        fst_dur_reg_t     dur;
        logic             trig_prev;
        logic             on;
        logic [CNT_W-1:0] cnt;
        logic [7:0]       rdata;
        logic             tpulse;
    } fst_state_t;

    localparam fst_state_t RST_STATE = '{
        lvl:       fst_level_reg_t'(FST_FLASH_RST),
        dur:       fst_dur_reg_t'(FST_DUR_RST[6:0]),
        trig_prev: 1'b0,
        on:        1'b0,
        cnt:       '0,
        rdata:     FST_RDATA_RST,
        tpulse:    1'b0
    };

    fst_state_t       state_ff;
    fst_state_t       nxt_state;
    logic [CNT_W-1:0] limit;
    logic             trig_rise;
    logic             flash_sel;
    logic             timer_start;
    logic             wr_level;
    logic             wr_dur;
    logic             timeout_hit;
    logic             level_release;

    // ****************************************************************
    // Decode.
    // ****************************************************************
    assign wr_level      = req_i.we && (req_i.addr == FST_FLASH_OFS);
    assign wr_dur        = req_i.we && (req_i.addr == FST_DUR_OFS);

    // Pulse timer terms.
    assign limit         =
        CNT_W'((32'(state_ff.dur.timeout_code) + 32'd1) * STEP_CYCLES);
    assign trig_rise     = trigger_i && !state_ff.trig_prev;
    assign flash_sel     = (state_ff.lvl.mode[1:0] == FST_MODE_FLASH[1:0]);
    assign timer_start   = trig_rise && flash_sel;
    // The count runs from zero, so the last cycle of a pulse is limit minus one.
    assign timeout_hit   = (state_ff.cnt >= limit - CNT_W'(1));
    assign level_release = !state_ff.lvl.trigger_sense_select && !trigger_i;

    // ****************************************************************
    // Readback.
    // ****************************************************************
    // Field by field, so that the unused duration bit can only read zero.
    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input fst_state_t st
    );
        logic [7:0] data;
        data = FST_RDATA_RST;
        unique case (addr)
            FST_FLASH_OFS: begin
                data[FST_SENSE_BIT]      = st.lvl.trigger_sense_select;
                data[FST_LEVEL_LSB +: 4] = st.lvl.flash_level_code;
                data[FST_MODE_LSB +: 3]  = st.lvl.mode;
            end
            FST_DUR_OFS: begin
                data[FST_LIMIT_LSB +: 2] = st.dur.switch_limit_sel;
                data[FST_CODE_LSB +: 5]  = st.dur.timeout_code;
                data[FST_LIMIT_LSB + 2]  = 1'b0;
            end
            default: begin
                data = FST_RDATA_RST;
            end
        endcase
        return data;
    endfunction : read_mux

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb begin
        nxt_state           = state_ff;
        nxt_state.trig_prev = trigger_i;
        nxt_state.tpulse    = 1'b0;

        // A torch mirror write lands after a level write in the same cycle.
        if (wr_level) begin
            nxt_state.lvl.trigger_sense_select = req_i.wdata[FST_SENSE_BIT];
            nxt_state.lvl.flash_level_code     = req_i.wdata[FST_LEVEL_LSB +: 4];
            nxt_state.lvl.mode = fst_mode_t'(req_i.wdata[FST_MODE_LSB +: 3]);
        end
        if (wr_dur) begin
            nxt_state.dur.switch_limit_sel = req_i.wdata[FST_LIMIT_LSB +: 2];
            nxt_state.dur.timeout_code     = req_i.wdata[FST_CODE_LSB +: 5];
        end
        if (torch_mode_we_i) begin
            nxt_state.lvl.mode = fst_mode_t'(torch_mode_i);
        end

        if (req_i.re) begin
            nxt_state.rdata = read_mux(req_i.addr, state_ff);
        end

        // A timeout clears only the flash selection and keeps voltage output.
        if (timer_start) begin
            nxt_state.on  = 1'b1;
            nxt_state.cnt = '0;
        end else if (state_ff.on) begin
            if (!flash_sel) begin
                nxt_state.on = 1'b0;
            end else if (timeout_hit) begin
                nxt_state.on       = 1'b0;
                nxt_state.tpulse   = 1'b1;
                nxt_state.lvl.mode = fst_mode_t'({nxt_state.lvl.mode[2], 2'b00});
            end else if (level_release) begin
                nxt_state.on = 1'b0;
            end else begin
                nxt_state.cnt = state_ff.cnt + CNT_W'(1);
            end
        end
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= RST_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // Every output is a field of the state register.
    assign reg_rdata_o        = state_ff.rdata;
    assign mode_o             = state_ff.lvl.mode;
    assign flash_on_o         = state_ff.on;
    assign flash_level_code_o = state_ff.lvl.flash_level_code;
    assign switch_limit_sel_o = state_ff.dur.switch_limit_sel;
    assign timeout_pulse_o    = state_ff.tpulse;

endmodule : fst_flash_strobe_timeout_ctrl
`default_nettype wire

// file: tb/fst_monitor.sv
/* Assertions on the flash register block ports. Assumes binding to its top module. */
`timescale 1ns/1ns
`default_nettype none
module fst_monitor
    import fst_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire fst_req_t   req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       torch_mode_we_i,
    input wire logic [2:0] mode_o,
    input wire logic       trigger_i,
    input wire logic       flash_on_o,
    input wire logic [3:0] flash_level_code_o,
    input wire logic [1:0] switch_limit_sel_o,
    input wire logic       timeout_pulse_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_arm;
        $rose(trigger_i) && mode_o[1:0] == 2'h3;
    endsequence
    sequence s_wr(logic [7:0] a);
        req_i.we && req_i.addr == a;
    endsequence
    AST_ARM: assert property (s_arm |=> flash_on_o) else $error("flash not lit");
    AST_OFF: assert property (!flash_on_o && !$rose(trigger_i) |=> !flash_on_o)
        else $error("flash lit without trigger");
    AST_CLR: assert property (timeout_pulse_o |-> !flash_on_o && mode_o[1:0] == 2'h0)
        else $error("timeout left flash armed");
    AST_SRC: assert property (timeout_pulse_o |-> $past(flash_on_o))
        else $error("timeout without pulse");
    AST_RD7: assert property (req_i.re && req_i.addr == FST_DUR_OFS |=> !reg_rdata_o[7])
        else $error("unused bit read one");
    AST_LIM: assert property (s_wr(FST_DUR_OFS) |=> switch_limit_sel_o == $past(req_i.wdata[6:5]))
        else $error("limit not updated");
    AST_LVL: assert property (s_wr(FST_FLASH_OFS) |=> flash_level_code_o == $past(req_i.wdata[6:3]))
        else $error("level not updated");
    AST_MIR: assert property (req_i.we && req_i.addr == FST_FLASH_OFS && !torch_mode_we_i
        |=> timeout_pulse_o || mode_o == $past(req_i.wdata[2:0])) else $error("mode not copied");
endmodule : fst_monitor
bind fst_flash_strobe_timeout_ctrl fst_monitor u_fst_monitor (.clk_i, .rstn_i, .req_i,
    .reg_rdata_o, .torch_mode_we_i, .mode_o, .trigger_i, .flash_on_o, .flash_level_code_o,
    .switch_limit_sel_o, .timeout_pulse_o);
`default_nettype wire

// file: tb/fst_host_model.sv
/* Host model: register accesses and torch mirror writes. Assumes drive at falling edges. */
`timescale 1ns/1ns
`default_nettype none
module fst_host_model
    import fst_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output var  fst_req_t   req_o,
    output var  logic       twe_o,
    output var  logic [2:0] tmode_o
);
    initial begin
        req_o = '0;
        twe_o = 1'b0;
        tmode_o = 3'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o = '{a, d, 1'b1, 1'b0};
        @(negedge clk_i);
        req_o = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        req_o = '{a, 8'h00, 1'b0, 1'b1};
        @(negedge clk_i);
        req_o = '0;
        d = rdata_i;
    endtask : rd
    task automatic tm(input logic [2:0] m);
        @(negedge clk_i);
        twe_o = 1'b1;
        tmode_o = m;
        @(negedge clk_i);
        twe_o = 1'b0;
        tmode_o = ~m;
    endtask : tm
endmodule : fst_host_model
`default_nettype wire

// file: tb/fst_flash_strobe_timeout_ctrl_tb_top.sv
/* Self-checking bench for the flash register block. Assumes STEP_CYCLES of 4. */
`timescale 1ns/1ns
`default_nettype none
module fst_flash_strobe_timeout_ctrl_tb_top;
    import fst_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} fst_row_t;
    logic       clk_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       trig = 1'b0;
    fst_req_t   req;
    logic       twe, on, tp;
    logic [2:0] tmode, mode;
    logic [7:0] rdata, r;
    logic [3:0] lvl;
    logic [1:0] lim;
    int         fail_count = 0;
    int         total_checks = 0;
    fst_row_t   rows [5] = '{'{8'hC0, 8'hFF, 8'h7F}, '{8'hC0, 8'h35, 8'h35},
        '{8'hB0, 8'h81, 8'h81}, '{8'hB0, 8'h7C, 8'h7C}, '{8'hA0, 8'h55, 8'h00}};
    always #50 clk_i = ~clk_i;
    fst_host_model u_fst_host_model (.clk_i(clk_i), .rdata_i(rdata), .req_o(req),
        .twe_o(twe), .tmode_o(tmode));
    fst_flash_strobe_timeout_ctrl #(.STEP_CYCLES(4)) u_fst_flash_strobe_timeout_ctrl (
        .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .reg_rdata_o(rdata),
        .torch_mode_we_i(twe), .torch_mode_i(tmode), .mode_o(mode), .trigger_i(trig),
        .flash_on_o(on), .flash_level_code_o(lvl), .switch_limit_sel_o(lim),
        .timeout_pulse_o(tp));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            $display("Error at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask : chk
    task automatic pulse(input logic [7:0] b, c, p, e, input logic [2:0] m);
        logic [7:0] n;
        logic [7:0] t;
        n = 8'h00;
        t = 8'h00;
        u_fst_host_model.wr(FST_DUR_OFS, c);
        u_fst_host_model.wr(FST_FLASH_OFS, b);
        for (int i = 0; i < 140; i++) begin
            trig = (i < 8) ? p[i] : 1'b0;
            @(negedge clk_i);
            n = n + {7'h0, on};
            t = t + {7'h0, tp};
        end
        chk(n, e);
        chk({5'h0, mode}, {5'h0, m});
        chk(t, {7'h0, (m[1:0] == 2'h0)});
        $display("Pulse test done");
    endtask : pulse
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (8) @(negedge clk_i);
        rstn_i = 1'b1;
        chk({on, lvl, mode}, 8'h68);
        chk({6'h0, lim}, 8'h02);
        u_fst_host_model.rd(FST_DUR_OFS, r);
        chk(r, FST_DUR_RST);
        foreach (rows[i]) begin
            u_fst_host_model.wr(rows[i].a, rows[i].d);
            u_fst_host_model.rd(rows[i].a, r);
            chk(r, rows[i].e);
            $display("Row %0d done", i);
        end
        u_fst_host_model.tm(3'h6);
        chk({5'h0, mode}, 8'h06);
        pulse(8'h0B, 8'h00, 8'h03, 8'd2, 3'h3);
        pulse(8'h0B, 8'h00, 8'hFF, 8'd4, 3'h0);
        pulse(8'h8B, 8'h00, 8'h01, 8'd4, 3'h0);
        pulse(8'h8B, 8'h01, 8'h01, 8'd8, 3'h0);
        pulse(8'h8B, 8'h1F, 8'h01, 8'd128, 3'h0);
        pulse(8'h8B, 8'h00, 8'h05, 8'd6, 3'h0);
        pulse(8'h8F, 8'h00, 8'h01, 8'd4, 3'h4);
        pulse(8'h8A, 8'h00, 8'h01, 8'd0, 3'h2);
        u_fst_host_model.wr(FST_FLASH_OFS, 8'h8B);
        trig = 1'b1;
        repeat (2) @(negedge clk_i);
        chk({7'h0, on}, 8'h01);
        rstn_i = 1'b0;
        trig = 1'b0;
        @(negedge clk_i);
        chk({on, lvl, mode}, 8'h68);
        chk({6'h0, lim}, 8'h02);
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
        u_fst_host_model.rd(FST_DUR_OFS, r);
        chk(r, FST_DUR_RST);
        chk({6'h0, tp, on}, 8'h00);
        $display("Reset test done");
        end_sim();
    end
    initial begin
        #1000000;
        fail_count++;
        end_sim();
    end
endmodule : fst_flash_strobe_timeout_ctrl_tb_top
`default_nettype wire
